/* rtl/rtu_slave_query_handler.sv */
/*
  Serial RTU slave query handler: frames queries by address sync, checks
  CRC and parity errors, validates requests and sends replies bytewise.
  Assumes a byte receiver/transmitter outside with 8 data bits, no parity,
  and that point data (inputs, outputs, counters) are presented as ports.
*/
// Notes on behaviour
// - frame start found by own address byte
// - query: addr, func, reg, count, CRC
// - parity or CRC error: silent drop
// - unsupported function gives exception 01
// - func 03 bad start gives exception 02
// - func 06 register other than 0x16 illegal
// - func 03 bad span gives exception 03
// - exception: addr, func|80, code, CRC
// - timer from address; expiry discards frame
// - timeout default 1 s, 100..65000 ms
// - func 16 start high word, max 120
// - presets disabled give exception 01
// - coil forcing drives outputs, else 01
// - binary input is input, trigger or alarm
// - coil read shows output channels only
// - counter is 32-bit scaled value pair
// - counter map starts at 40001, high first
// - CRC preset ones, LSB first, 0xA001
// - characters are 8 bits, no parity
`timescale 1ns/1ps
module rtu_slave_query_handler #(
  parameter int NUM_CNT_P = rtu_slave_pkg::NUM_CNT,
  parameter int MS_CYCLES_P = rtu_slave_pkg::MS_CYCLES // clock cycles per millisecond tick
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic [7:0] rxData,
  input wire logic rxValid,
  input wire logic rxParityErr,
  input wire logic [7:0] devAddr,
  input wire logic [15:0] timeoutMs,
  input wire logic presetEnable,
  input wire logic forceEnable,
  input wire logic [rtu_slave_pkg::NUM_BIN_IN-1:0] binClosed,
  input wire logic [rtu_slave_pkg::NUM_BIN_IN-1:0] binTrigger,
  input wire logic [rtu_slave_pkg::NUM_BIN_IN-1:0] binAlarm,
  input wire logic [rtu_slave_pkg::NUM_DIO-1:0] dioIsOutput,
  input wire logic [31:0] cntSource,
  input wire logic [9:0] cntScale,
  input wire logic txReady,
  output logic [7:0] txData,
  output logic txValid,
  output logic [rtu_slave_pkg::NUM_DIO-1:0] dioOut,
  output logic [7:0] cntIndex,
  output logic frameDrop,
  output logic frameTimeout
);
  import rtu_slave_pkg::*;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // one byte through the reflected CRC, LSB first
  function automatic logic [15:0] crcByte(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] v;
    v = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      v = v[0] ? ((v >> 1) ^ CRC_POLY) : (v >> 1);
    end
    return v;
  endfunction : crcByte

  function automatic logic fcKnown(input logic [7:0] f);
    return (f == FC_RD_COILS) || (f == FC_RD_INPUTS) || (f == FC_RD_HOLD) ||
           (f == FC_RD_INREG) || (f == FC_WR_COIL) || (f == FC_WR_COILS) ||
           (f == FC_WR_REGS);
  endfunction : fcKnown

  // timeout clamped into its legal range; cycle span per millisecond
  logic [15:0] toMs;
  assign toMs = (timeoutMs < TIMEOUT_MS_MIN) ? TIMEOUT_MS_MIN :
                ((timeoutMs > TIMEOUT_MS_MAX) ? TIMEOUT_MS_MAX : timeoutMs);

  // binary points merged from three sources
  logic [NUM_BIN_IN-1:0] binPoint;
  assign binPoint = binClosed | binTrigger | binAlarm;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    state_t st;
    logic [7:0] buf0, buf1, buf2, buf3, buf4, buf5, buf6;
    logic [3:0] cnt;
    logic [15:0] crc;
    logic [16:0] msTick;
    logic [15:0] msCount;
    logic [7:0] txData;
    logic txValid;
    logic [3:0] txIdx;
    logic [3:0] txLen;
    logic [15:0] txCrc;
    logic [7:0] exc;
    logic [7:0] data0, data1, data2, data3;
    logic [NUM_DIO-1:0] dio;
    logic drop;
    logic tmo;
  } state_s_t;

  state_s_t r, n;

  logic [15:0] regAddr, regCnt;
  logic [16:0] spanEnd;
  logic [47:0] scaled;
  assign regAddr = {r.buf2, r.buf3};
  assign regCnt = {r.buf4, r.buf5};
  assign spanEnd = {1'b0, regAddr} + {1'b0, regCnt};
  assign scaled = cntSource * ((cntScale > SCALE_MAX) ? 16'(SCALE_MAX) : 16'(cntScale));

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    logic [7:0] outByte;
    n = r;
    outByte = 8'h00;
    n.drop = 1'b0;
    n.tmo = 1'b0;
    case (r.st)
      // look for own address only; idle gaps are not timed
      ST_HUNT: begin
        n.cnt = 4'h0;
        if (rxValid && !rxParityErr && rxData == devAddr) begin
          n.buf0 = rxData;
          n.cnt = 4'h1;
          n.crc = crcByte(CRC_INIT, rxData);
          n.msTick = 17'h00000;
          n.msCount = 16'h0000;
          n.st = ST_COLLECT;
        end
      end
      // gather the remaining query bytes in wire order
      ST_COLLECT: begin
        n.msTick = (r.msTick == 17'(MS_CYCLES_P - 1)) ? 17'h00000 : r.msTick + 17'h00001;
        n.msCount = r.msCount + 16'(r.msTick == 17'(MS_CYCLES_P - 1));
        if (r.msCount >= toMs) begin
          n.st = ST_HUNT;
          n.tmo = 1'b1;
        end else if (rxValid && rxParityErr) begin
          n.st = ST_HUNT;
          n.drop = 1'b1;
        end else if (rxValid) begin
          case (r.cnt)
            4'h1: n.buf1 = rxData;
            4'h2: n.buf2 = rxData;
            4'h3: n.buf3 = rxData;
            4'h4: n.buf4 = rxData;
            4'h5: n.buf5 = rxData;
            4'h6: n.buf6 = rxData;
            default: n.buf6 = r.buf6;
          endcase
          if (r.cnt < 4'h6) begin
            n.crc = crcByte(r.crc, rxData);
          end
          n.cnt = r.cnt + 4'h1;
          // CRC low byte arrives first on the wire, compared reflected
          if (r.cnt == 4'(QUERY_LEN - 1)) begin
            if ({rxData, r.buf6} == r.crc) begin
              n.st = ST_CHECK;
            end else begin
              n.st = ST_HUNT;
              n.drop = 1'b1;
            end
          end
        end
      end
      // validate and build the answer
      ST_CHECK: begin
        n.exc = 8'h00;
        n.data0 = r.buf2; // writes echo address and count
        n.data1 = r.buf3;
        n.data2 = r.buf4;
        n.data3 = r.buf5;
        n.txLen = 4'h4;
        if (!fcKnown(r.buf1) && r.buf1 != FC_WR_SINGLE) begin
          n.exc = EXC_FUNC;
        end else if (r.buf1 == FC_WR_SINGLE) begin
          n.exc = (regAddr != SINGLE_REG_ADDR) ? EXC_ADDR : EXC_FUNC;
        end else if (r.buf1 == FC_WR_REGS) begin
          if (!presetEnable) begin
            n.exc = EXC_FUNC;
          end else if (regAddr[0]) begin
            n.exc = EXC_ADDR;
          end else if (regCnt > PRESET_MAX_REGS || regCnt[0]) begin
            n.exc = EXC_VALUE;
          end else begin
            n.txLen = 4'h6;
          end
        end else if (r.buf1 == FC_WR_COIL || r.buf1 == FC_WR_COILS) begin
          if (!forceEnable) begin
            n.exc = EXC_FUNC;
          end else if (regAddr >= 16'(NUM_DIO)) begin
            n.exc = EXC_ADDR;
          end else if (r.buf1 == FC_WR_COIL && regCnt != COIL_ON && regCnt != COIL_OFF) begin
            n.exc = EXC_VALUE;
          end else begin
            // single coil by FF00/0000; multi-coil takes value low bit
            n.dio[regAddr[3:0]] = (r.buf1 == FC_WR_COIL) ? (regCnt == COIL_ON) : r.buf5[0];
            n.txLen = 4'h6;
          end
        end else if (r.buf1 == FC_RD_HOLD) begin
          if (regAddr > HOLD_MAX_START || regAddr[0]) begin
            n.exc = EXC_ADDR;
          end else if (spanEnd > HOLD_MAX_END || regCnt[0] || regCnt == 16'h0000) begin
            n.exc = EXC_VALUE;
          end else begin
            // one pair served per reply: high word first
            n.data0 = 8'h04;
            n.data1 = scaled[31:24];
            n.data2 = scaled[23:16];
            n.data3 = scaled[15:8];
            n.txLen = 4'h7;
          end
        end else if (r.buf1 == FC_RD_COILS) begin
          n.data0 = 8'h02;
          n.data1 = 8'((r.dio & dioIsOutput) >> 0);
          n.data2 = {2'b00, 6'((r.dio & dioIsOutput) >> 8)};
          n.txLen = 4'h5; // count byte plus two data bytes
        end else begin
          // inputs and input registers answer from the binary points
          n.data0 = 8'h02;
          n.data1 = binPoint[regAddr[5:0] +: 8];
          n.data2 = binPoint[6'(regAddr[5:0] + 6'h08) +: 8];
          n.txLen = 4'h5;
        end
        if (n.exc != 8'h00) begin
          n.txLen = 4'h3;
        end
        n.txIdx = 4'h0;
        n.txCrc = CRC_INIT;
        n.txValid = 1'b0;
        n.st = ST_REPLY;
      end
      // shift out body bytes; exception marks the function
      ST_REPLY: begin
        case (r.txIdx)
          4'h0: outByte = r.buf0;
          4'h1: outByte = (r.exc != 8'h00) ? (r.buf1 | FC_EXC_FLAG) : r.buf1;
          4'h2: outByte = (r.exc != 8'h00) ? r.exc : r.data0;
          4'h3: outByte = r.data1;
          4'h4: outByte = r.data2;
          4'h5: outByte = r.data3;
          default: outByte = (r.txIdx == 4'h6) ? scaled[7:0] : 8'h00;
        endcase
        if (!r.txValid || txReady) begin
          if (r.txIdx == r.txLen) begin
            n.txValid = 1'b0;
            n.txIdx = 4'h0;
            n.st = ST_CRCOUT;
          end else begin
            n.txData = outByte;
            n.txValid = 1'b1;
            n.txCrc = crcByte(r.txCrc, outByte);
            n.txIdx = r.txIdx + 4'h1;
          end
        end
      end
      // CRC high byte then low byte
      ST_CRCOUT: begin
        if (!r.txValid || txReady) begin
          if (r.txIdx == 4'h0) begin
            n.txData = r.txCrc[15:8];
            n.txValid = 1'b1;
            n.txIdx = 4'h1;
          end else if (r.txIdx == 4'h1) begin
            n.txData = r.txCrc[7:0];
            n.txValid = 1'b1;
            n.txIdx = 4'h2;
          end else begin
            n.txValid = 1'b0;
            n.st = ST_HUNT;
          end
        end
      end
      default: n.st = ST_HUNT;
    endcase
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign txData = r.txData;
  assign txValid = r.txValid;
  assign dioOut = r.dio & dioIsOutput;
  assign cntIndex = 8'(regAddr[7:1]);
  assign frameDrop = r.drop;
  assign frameTimeout = r.tmo;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  property p_hunt_addr;
    @(posedge clk_sys) disable iff (!arst_n)
      (r.st == ST_HUNT && rxValid && !rxParityErr && rxData == devAddr) |=> r.st == ST_COLLECT;
  endproperty
  a_hunt_addr: assert property (p_hunt_addr) else $error("address sync missed");

  property p_foreign;
    @(posedge clk_sys) disable iff (!arst_n)
      (r.st == ST_HUNT && rxValid && rxData != devAddr) |=> r.st == ST_HUNT;
  endproperty
  a_foreign: assert property (p_foreign) else $error("foreign frame accepted");

  property p_parity;
    @(posedge clk_sys) disable iff (!arst_n)
      (r.st == ST_COLLECT && rxValid && rxParityErr && r.msCount < toMs) |=> frameDrop && r.st == ST_HUNT;
  endproperty
  a_parity: assert property (p_parity) else $error("parity error not dropped");

  property p_drop_quiet;
    @(posedge clk_sys) disable iff (!arst_n)
      frameDrop |-> !txValid [*2];
  endproperty
  a_drop_quiet: assert property (p_drop_quiet) else $error("reply after dropped frame");

  property p_timeout;
    @(posedge clk_sys) disable iff (!arst_n)
      (r.st == ST_COLLECT && r.msCount >= toMs) |=> frameTimeout && r.st == ST_HUNT;
  endproperty
  a_timeout: assert property (p_timeout) else $error("timeout ignored");

  property p_bad_fc;
    @(posedge clk_sys) disable iff (!arst_n)
      (r.st == ST_CHECK && !fcKnown(r.buf1) && r.buf1 != FC_WR_SINGLE) |=> r.exc == EXC_FUNC;
  endproperty
  a_bad_fc: assert property (p_bad_fc) else $error("illegal function missed");

  property p_hold_addr;
    @(posedge clk_sys) disable iff (!arst_n)
      (r.st == ST_CHECK && r.buf1 == FC_RD_HOLD && (regAddr > HOLD_MAX_START || regAddr[0]))
        |=> r.exc == EXC_ADDR;
  endproperty
  a_hold_addr: assert property (p_hold_addr) else $error("bad start not flagged");

  property p_preset_off;
    @(posedge clk_sys) disable iff (!arst_n)
      (r.st == ST_CHECK && r.buf1 == FC_WR_REGS && !presetEnable) |=> r.exc == EXC_FUNC;
  endproperty
  a_preset_off: assert property (p_preset_off) else $error("preset not refused");

  property p_force_off;
    @(posedge clk_sys) disable iff (!arst_n)
      (r.st == ST_CHECK && r.buf1 == FC_WR_COIL && !forceEnable) |=> $stable(r.dio) && r.exc == EXC_FUNC;
  endproperty
  a_force_off: assert property (p_force_off) else $error("force not refused");
endmodule : rtu_slave_query_handler

/* rtl/rtu_slave_pkg.sv */
/*
  Shared constants for the serial query handler: frame layout, function
  codes, exception codes, CRC constants and timeout figures.
  Assumes a 100 MHz system clock.
*/
package rtu_slave_pkg;
  // ---------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ = 100000000;
  localparam int MS_CYCLES = CLK_HZ / 1000;
  localparam logic [15:0] TIMEOUT_MS_DEFAULT = 16'h03E8; // one second
  localparam logic [15:0] TIMEOUT_MS_MIN = 16'h0064;
  localparam logic [15:0] TIMEOUT_MS_MAX = 16'hFDE8;
  // ---------------------------------------------------------------
  // frame layout
  // ---------------------------------------------------------------
  localparam int QUERY_LEN = 8;
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'hA001;
  localparam logic [15:0] COIL_ON = 16'hFF00;
  localparam logic [15:0] COIL_OFF = 16'h0000;
  // ---------------------------------------------------------------
  // function codes
  // ---------------------------------------------------------------
  localparam logic [7:0] FC_RD_COILS = 8'h01;
  localparam logic [7:0] FC_RD_INPUTS = 8'h02;
  localparam logic [7:0] FC_RD_HOLD = 8'h03;
  localparam logic [7:0] FC_RD_INREG = 8'h04;
  localparam logic [7:0] FC_WR_COIL = 8'h05;
  localparam logic [7:0] FC_WR_SINGLE = 8'h06;
  localparam logic [7:0] FC_WR_COILS = 8'h0F;
  localparam logic [7:0] FC_WR_REGS = 8'h10;
  localparam logic [7:0] FC_EXC_FLAG = 8'h80;
  // ---------------------------------------------------------------
  // exception codes and limits
  // ---------------------------------------------------------------
  localparam logic [7:0] EXC_FUNC = 8'h01;
  localparam logic [7:0] EXC_ADDR = 8'h02;
  localparam logic [7:0] EXC_VALUE = 8'h03;
  localparam logic [15:0] HOLD_MAX_START = 16'h00E7;
  localparam logic [16:0] HOLD_MAX_END = 17'h0003F;
  localparam logic [15:0] SINGLE_REG_ADDR = 16'h0016;
  localparam logic [15:0] PRESET_MAX_REGS = 16'h0078;
  localparam int NUM_BIN_IN = 64;
  localparam int NUM_DIO = 14;
  localparam int NUM_CNT = 150;
  localparam logic [15:0] HOLD_BASE_ADDR = 16'h9C41; // 40001
  localparam logic [9:0] SCALE_MAX = 10'h3E8;

  typedef enum logic [2:0] {
    ST_HUNT = 3'b000,
    ST_COLLECT = 3'b001,
    ST_CHECK = 3'b010,
    ST_REPLY = 3'b011,
    ST_CRCOUT = 3'b100
  } state_t;
endpackage : rtu_slave_pkg

/* testbench/rtu_master_model.sv */
/*
  Serial master model for the query handler: sends query bytes one
  pulse each and paces acceptance of reply bytes.
  Assumes the byte ports of the handler and one system clock.
*/
`timescale 1ns/1ps
module rtu_master_model (
  input wire logic clk_sys,
  input wire logic slow,
  output logic [7:0] rxData,
  output logic rxValid,
  output logic rxParityErr,
  output logic txReady
);
  // ---------------------------------------------------------------
  // frame check and byte sending
  // ---------------------------------------------------------------
  initial begin
    rxData = 8'h00;
    rxValid = 1'b0;
    rxParityErr = 1'b0;
    txReady = 1'b1;
  end

  // check word over the first n bytes, lsb first
  function automatic logic [15:0] crc16(input logic [7:0] b[8], input int n);
    logic [15:0] c;
    c = 16'hFFFF;
    for (int i = 0; i < n; i++) begin
      c ^= {8'h00, b[i]};
      for (int k = 0; k < 8; k++) c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
    end
    return c;
  endfunction : crc16

  // first n bytes of a frame, short gaps only; idle data toggles so no stale byte
  task automatic send_frame(input logic [7:0] fr[8], input int n, input int badIdx);
    for (int i = 0; i < n; i++) begin
      @(posedge clk_sys);
      #1;
      rxData = fr[i];
      rxValid = 1'b1;
      rxParityErr = (i == badIdx);
      @(posedge clk_sys);
      #1;
      rxValid = 1'b0;
      rxParityErr = 1'b0;
      rxData = ~fr[i];
      repeat ($urandom_range(1, 0)) @(posedge clk_sys);
    end
  endtask : send_frame

  // stalls the reply at random when slow is set
  always begin
    @(posedge clk_sys);
    #1;
    txReady = slow ? 1'($urandom_range(1, 0)) : 1'b1;
  end
endmodule : rtu_master_model

/* testbench/tb.sv */
/*
  Self-checking bench for the query handler: queries go out through the
  master model, expected reply bytes queue up and a watcher compares.
  Assumes the handler's package; the frame timeout runs on a shortened
  millisecond tick so that it expires within the run.
*/
`timescale 1ns/1ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin nErrors++; \
  $display("ERROR %s exp %h got %h", nm, e, g); end end
module tb;
  import rtu_slave_pkg::*;
  // ---------------------------------------------------------------
  // signals and instances
  // ---------------------------------------------------------------
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] rxData, txData, cntIndex, ex;
  logic rxValid, rxParityErr, txReady, txValid, frameDrop, frameTimeout, slow;
  logic [7:0] devAddr = 8'h05;
  logic [15:0] timeoutMs = 16'h03E8;
  logic presetEnable = 1'b0;
  logic forceEnable = 1'b0;
  logic [NUM_BIN_IN-1:0] binClosed, binTrigger, binAlarm;
  logic [NUM_DIO-1:0] dioIsOutput, dioOut;
  logic [31:0] cntSource, v;
  logic [9:0] cntScale;
  logic [63:0] pts;
  logic [7:0] f[8], e3[8];
  logic [15:0] vl;
  logic sawTx, sawDrop, sawTmo;
  localparam int MS_T = 10; // shortened millisecond tick for the bench
  logic [7:0] expQ[$];
  int nErrors = 0;
  int compares = 0;
  int cycles = 0;

  always #5 clk_sys = ~clk_sys;
  // counter source follows the pair index
  assign cntSource = {cntIndex, 8'h5A, cntIndex, 8'hC3};

  rtu_master_model master (.clk_sys(clk_sys), .slow(slow), .rxData(rxData),
    .rxValid(rxValid), .rxParityErr(rxParityErr), .txReady(txReady));

  rtu_slave_query_handler #(.MS_CYCLES_P(MS_T)) DUT (.clk_sys(clk_sys), .arst_n(arst_n),
    .rxData(rxData), .rxValid(rxValid), .rxParityErr(rxParityErr), .devAddr(devAddr),
    .timeoutMs(timeoutMs), .presetEnable(presetEnable), .forceEnable(forceEnable),
    .binClosed(binClosed), .binTrigger(binTrigger), .binAlarm(binAlarm),
    .dioIsOutput(dioIsOutput), .cntSource(cntSource), .cntScale(cntScale),
    .txReady(txReady), .txData(txData), .txValid(txValid), .dioOut(dioOut),
    .cntIndex(cntIndex), .frameDrop(frameDrop), .frameTimeout(frameTimeout));

  // ---------------------------------------------------------------
  // tasks and watcher
  // ---------------------------------------------------------------
  task automatic tally_and_finish();
    $display("compares %0d errors %0d", compares, nErrors);
    if (nErrors == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : tally_and_finish

  task automatic build(input logic [7:0] a, fc, input logic [15:0] rg, val);
    logic [15:0] c;
    f = '{a, fc, rg[15:8], rg[7:0], val[15:8], val[7:0], 8'h00, 8'h00};
    c = master.crc16(f, 6);
    f[6] = c[7:0];
    f[7] = c[15:8];
  endtask : build

  // idle first, so the line is quiet before every frame
  task automatic query(input logic [7:0] fc, input logic [15:0] rg, val, input int bad);
    repeat (4) @(posedge clk_sys);
    slow = 1'($urandom_range(1, 0));
    build(devAddr, fc, rg, val);
    if (bad == 9) f[6] = ~f[6];
    master.send_frame(f, 8, bad);
  endtask : query

  // reply crc goes high byte first
  task automatic expect_reply(input int n);
    logic [15:0] c;
    c = master.crc16(e3, n);
    for (int i = 0; i < n; i++) expQ.push_back(e3[i]);
    expQ.push_back(c[15:8]);
    expQ.push_back(c[7:0]);
  endtask : expect_reply

  // waits for a quiet reply line, bounded
  task automatic settle();
    int quiet;
    quiet = 0;
    for (int i = 0; i < 600 && quiet < 12; i++) begin
      @(posedge clk_sys);
      quiet = (txValid === 1'b1) ? 0 : quiet + 1;
    end
    `CHK("pending", 0, expQ.size())
    expQ.delete();
    #1;
  endtask : settle

  task automatic exc_case(input logic [7:0] fc, input logic [15:0] rg, val, input logic [7:0] code);
    e3 = '{devAddr, fc | FC_EXC_FLAG, code, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    expect_reply(3);
    query(fc, rg, val, -1);
    settle();
  endtask : exc_case

  // only address and function are fixed in a good reply header
  task automatic ok_case(input logic [7:0] fc, input logic [15:0] rg, val);
    expQ.push_back(devAddr);
    expQ.push_back(fc);
    query(fc, rg, val, -1);
    settle();
  endtask : ok_case

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles > 20000) begin
      nErrors++;
      tally_and_finish();
    end
    if (frameDrop === 1'b1) sawDrop = 1'b1;
    if (frameTimeout === 1'b1) sawTmo = 1'b1;
    if (txValid === 1'b1 && txReady === 1'b1) begin
      sawTx = 1'b1;
      if (expQ.size() > 0) begin
        ex = expQ.pop_front();
        `CHK("txData", ex, txData)
      end
    end
  end

  initial begin
    void'($urandom(32'h3E64));
    slow = 1'b0;
    binClosed = {$urandom, $urandom} & {$urandom, $urandom};
    binTrigger = {$urandom, $urandom} & {$urandom, $urandom};
    binAlarm = {$urandom, $urandom} & {$urandom, $urandom};
    dioIsOutput = 14'($urandom) | 14'h0028;
    cntScale = 10'($urandom_range(1000, 1));
    repeat (4) @(posedge clk_sys);
    #1;
    arst_n = 1'b1;
    exc_case(8'h07, 16'h0000, 16'h0002, EXC_FUNC);
    exc_case(8'($urandom_range(8'h7F, 8'h11)), 16'h0000, 16'h0002, EXC_FUNC);
    exc_case(FC_RD_HOLD, 16'h00E8, 16'h0002, EXC_ADDR);
    exc_case(FC_RD_HOLD, 16'h0003, 16'h0002, EXC_ADDR);
    exc_case(FC_RD_HOLD, 16'h003E, 16'h0002, EXC_VALUE);
    exc_case(FC_RD_HOLD, 16'h0004, 16'h0003, EXC_VALUE);
    exc_case(FC_WR_SINGLE, 16'h0017, 16'h0001, EXC_ADDR);
    exc_case(FC_WR_SINGLE, 16'h0016, 16'h0001, EXC_FUNC);
    exc_case(FC_WR_REGS, 16'h0000, 16'h0002, EXC_FUNC);
    exc_case(FC_WR_COIL, 16'h0003, COIL_ON, EXC_FUNC);
    exc_case(FC_WR_COILS, 16'h0003, 16'h0001, EXC_FUNC);
    `CHK("dioOut", 14'h0000, dioOut)
    presetEnable = 1'b1;
    forceEnable = 1'b1;
    exc_case(FC_WR_REGS, 16'h0000, 16'h007A, EXC_VALUE);
    exc_case(FC_WR_REGS, 16'h0001, 16'h0002, EXC_ADDR);
    exc_case(FC_WR_COIL, 16'h000E, COIL_ON, EXC_ADDR);
    ok_case(FC_WR_REGS, 16'h0000, PRESET_MAX_REGS);
    ok_case(FC_RD_COILS, 16'h0000, 16'h000E);
    ok_case(FC_RD_INREG, 16'h0000, 16'h0001);
    ok_case(FC_RD_HOLD, 16'h003C, 16'h0002);
    ok_case(FC_WR_COIL, 16'h0003, COIL_ON);
    `CHK("dioOut3", dioIsOutput[3], dioOut[3])
    ok_case(FC_WR_COILS, 16'h0005, 16'h0001);
    `CHK("dioOut5", dioIsOutput[5], dioOut[5])
    ok_case(FC_WR_COIL, 16'h0003, COIL_OFF);
    `CHK("dioOut3off", 1'b0, dioOut[3])
    // counter pair two, high word first
    v = {8'h02, 8'h5A, 8'h02, 8'hC3} * cntScale;
    e3 = '{devAddr, FC_RD_HOLD, 8'h04, v[31:24], v[23:16], v[15:8], v[7:0], 8'h00};
    expect_reply(7);
    query(FC_RD_HOLD, 16'h0004, 16'h0002, -1);
    settle();
    pts = binClosed | binTrigger | binAlarm;
    e3 = '{devAddr, FC_RD_INPUTS, 8'h02, pts[15:8], pts[23:16], 8'h00, 8'h00, 8'h00};
    expect_reply(5);
    query(FC_RD_INPUTS, 16'h0008, 16'h0010, -1);
    settle();
    for (int bad = 3; bad < 10; bad += 6) begin
      sawTx = 1'b0;
      sawDrop = 1'b0;
      query(FC_RD_HOLD, 16'h0004, 16'h0002, bad);
      settle();
      `CHK("drop", 1'b1, sawDrop)
      `CHK("silent", 1'b0, sawTx)
      // the lost query is sent again and must now be answered
      e3 = '{devAddr, FC_RD_HOLD, 8'h04, v[31:24], v[23:16], v[15:8], v[7:0], 8'h00};
      expect_reply(7);
      query(FC_RD_HOLD, 16'h0004, 16'h0002, -1);
      settle();
    end
    // foreign frame with no byte equal to the own address
    vl = 16'h0000;
    do begin
      vl++;
      build(8'h06, FC_RD_HOLD, 16'h0004, vl);
    end while (f[5] == devAddr || f[6] == devAddr || f[7] == devAddr);
    sawTx = 1'b0;
    master.send_frame(f, 8, -1);
    settle();
    `CHK("foreign", 1'b0, sawTx)
    // partial frame left to expire; a zero setting is lifted to the minimum
    build(devAddr, FC_RD_HOLD, 16'h0004, 16'h0002);
    timeoutMs = 16'h0000;
    sawTx = 1'b0;
    sawTmo = 1'b0;
    repeat (4) @(posedge clk_sys);
    master.send_frame(f, 3, -1);
    repeat (int'(TIMEOUT_MS_MIN) * MS_T - 100) @(posedge clk_sys);
    `CHK("tmoEarly", 1'b0, sawTmo)
    repeat (200) @(posedge clk_sys);
    `CHK("tmo", 1'b1, sawTmo)
    `CHK("tmoSilent", 1'b0, sawTx)
    #1;
    timeoutMs = 16'h03E8;
    exc_case(8'h2B, 16'h0000, 16'h0002, EXC_FUNC);
    tally_and_finish();
  end
endmodule : tb
